// ===== verilog/seg_decode.sv
// register bank and decode for segment chip-select, s/g base and timer base
//
// Contract
// - an even attribute bit set grants chip-select for reads of its segment.
// - an even attribute bit clear gives no chip-select for reads of its segment.
// - an odd attribute bit grants chip-select for writes of its segment, clear denies it.
// - both grants clear, or global enable clear, makes the segment inaccessible.
// - first attribute register pairs map to 0C0000h..0CFFFFh, high bit of a pair is write.
// - second attribute register pairs map to 0D0000h..0DFFFFh, lowest pair lowest segment.
// - third attribute register pairs map to 0E0000h..0EFFFFh in the same way.
// - the s/g base gives io bits 15..8 of the s/g registers and resets to 04h.
// - timer base bits 15..2 compare with io address bits 15..2.
// - timer base bit 0 enables the timer decode; reset value 0078h.
//
// Added by the designer: the address-and-strobe port.
module seg_decode
  import seg_decode_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire reg_req_type reg_req_i,
  output logic      [7:0]  reg_rdata_o,
  input  wire mem_req_type mem_req_i,
  input  wire logic        io_valid_i,
  input  wire logic [15:0] io_addr_i,
  output logic             mem_select_out_n_o,
  output logic             timer_select_o,
  output logic             sg_select_o,
  output logic      [7:0]  sg_base_o
);

  typedef struct packed {
    logic [7:0]  attr_c;
    logic [7:0]  attr_d;
    logic [7:0]  attr_e;
    logic [7:0]  sg_base;
    logic [15:0] tmr_base;
    logic [7:0]  cs_ctrl;
    logic [7:0]  rdata;
    logic        mem_sel_n;
    logic        tmr_sel;
    logic        sg_sel;
  } state_type;

  state_type state_q;
  state_type state_d;

  logic [SEG_COUNT-1:0] seg_hit;
  logic [23:0]          all_attr;
  logic [SEG_COUNT-1:0] segment_read_grant;
  logic [SEG_COUNT-1:0] segment_write_grant;

  segment_match u_match
  (
    .addr_i (mem_req_i.addr),
    .hit_o  (seg_hit)
  );

  // read data for one register offset
  function automatic logic [7:0] reg_read(input state_type s, input logic [7:0] a);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      ATTR_C_OFS:      v = s.attr_c;
      ATTR_D_OFS:      v = s.attr_d;
      ATTR_E_OFS:      v = s.attr_e;
      SG_BASE_OFS:     v = s.sg_base;
      TMR_BASE_LO_OFS: v = s.tmr_base[7:0];
      TMR_BASE_HI_OFS: v = s.tmr_base[15:8];
      CS_CTRL_OFS:     v = s.cs_ctrl;
      default:         v = 8'h00;
    endcase
    return v;
  endfunction

  always_comb
  begin
    all_attr = {state_q.attr_e, state_q.attr_d, state_q.attr_c};
    for (int i = 0; i < SEG_COUNT; i++)
    begin
      segment_read_grant[i]  = all_attr[2*i];
      segment_write_grant[i] = all_attr[2*i+1];
    end
  end

  always_comb
  begin
    state_d = state_q;
    if (reg_req_i.wr)
    begin
      case (reg_req_i.addr)
        ATTR_C_OFS:      state_d.attr_c = reg_req_i.wdata;
        ATTR_D_OFS:      state_d.attr_d = reg_req_i.wdata;
        ATTR_E_OFS:      state_d.attr_e = reg_req_i.wdata;
        SG_BASE_OFS:     state_d.sg_base = reg_req_i.wdata;
        TMR_BASE_LO_OFS: state_d.tmr_base[7:0] = reg_req_i.wdata;
        TMR_BASE_HI_OFS: state_d.tmr_base[15:8] = reg_req_i.wdata;
        CS_CTRL_OFS:     state_d.cs_ctrl = reg_req_i.wdata;
        default:         state_d.cs_ctrl = state_q.cs_ctrl;
      endcase
    end
    state_d.rdata = reg_req_i.rd ? reg_read(state_q, reg_req_i.addr) : 8'h00;
    // chip-select needs global enable and a grant matching direction
    state_d.mem_sel_n = !(mem_req_i.valid && state_q.cs_ctrl[CS_ENABLE_BIT]
      && |(seg_hit & (mem_req_i.write ? segment_write_grant
                                      : segment_read_grant)));
    // timer compare ignores bits 1:0
    state_d.tmr_sel = io_valid_i && state_q.tmr_base[TMR_ENABLE_BIT]
      && (io_addr_i[15:TMR_ADDR_LSB] == state_q.tmr_base[15:TMR_ADDR_LSB]);
    state_d.sg_sel = io_valid_i && (io_addr_i[15:8] == state_q.sg_base);
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_q.attr_c    <= ATTR_RESET;
      state_q.attr_d    <= ATTR_RESET;
      state_q.attr_e    <= ATTR_RESET;
      state_q.sg_base   <= SG_BASE_RESET;
      state_q.tmr_base  <= TMR_BASE_RESET;
      state_q.cs_ctrl   <= CS_CTRL_RESET;
      state_q.rdata     <= 8'h00;
      state_q.mem_sel_n <= 1'b1;
      state_q.tmr_sel   <= 1'b0;
      state_q.sg_sel    <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  assign reg_rdata_o        = state_q.rdata;
  assign mem_select_out_n_o = state_q.mem_sel_n;
  assign timer_select_o     = state_q.tmr_sel;
  assign sg_select_o        = state_q.sg_sel;
  assign sg_base_o          = state_q.sg_base;

endmodule

// ===== include/seg_decode_pkg.sv
// package: register map, field layout and carriers of the segment decode block
package seg_decode_pkg;

  localparam logic [7:0]  ATTR_C_OFS        = 8'h54;
  localparam logic [7:0]  ATTR_D_OFS        = 8'h55;
  localparam logic [7:0]  ATTR_E_OFS        = 8'h56;
  localparam logic [7:0]  SG_BASE_OFS       = 8'h57;
  localparam logic [7:0]  TMR_BASE_LO_OFS   = 8'h80;
  localparam logic [7:0]  TMR_BASE_HI_OFS   = 8'h81;
  localparam logic [7:0]  CS_CTRL_OFS       = 8'h90;

  localparam logic [7:0]  ATTR_RESET        = 8'h00;
  localparam logic [7:0]  SG_BASE_RESET     = 8'h04;
  localparam logic [15:0] TMR_BASE_RESET    = 16'h0078;
  localparam logic [7:0]  CS_CTRL_RESET     = 8'h00;

  localparam int          CS_ENABLE_BIT     = 4;
  localparam int          TMR_ENABLE_BIT    = 0;
  localparam int          TMR_ADDR_LSB      = 2;

  localparam logic [7:0]  SEG_REGION_HI     = 8'h0c;
  localparam logic [1:0]  SEG_REGION_LAST   = 2'h2;
  localparam int          SEG_COUNT         = 12;
  localparam int          SEG_LSB           = 14;

  // software register port
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_type;

  // memory access presented for decode
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [31:0] addr;
  } mem_req_type;

endpackage

// ===== verilog/segment_match.sv
// one-hot segment hit from a memory address inside 0C0000h-0EFFFFh
module segment_match
  import seg_decode_pkg::*;
(
  input  wire logic [31:0]          addr_i,
  output logic      [SEG_COUNT-1:0] hit_o
);

  logic [3:0] seg_idx;
  logic       in_region;

  always_comb
  begin
    seg_idx   = {addr_i[17:16] - 2'h0, addr_i[15:14]};
    in_region = (addr_i[31:20] == 12'h000_0) && (addr_i[19:18] == 2'h3)
                && (addr_i[17:16] <= SEG_REGION_LAST);
    hit_o     = '0;
    if (in_region)
    begin
      hit_o[seg_idx] = 1'b1;
    end
  end

endmodule

// ===== verification/seg_decode_assertions.sv
// checker: port-level checks of the segment decode block
module seg_decode_checker
  import seg_decode_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire reg_req_type reg_req_i,
  input wire logic [7:0]  reg_rdata_o,
  input wire mem_req_type mem_req_i,
  input wire logic        io_valid_i,
  input wire logic [15:0] io_addr_i,
  input wire logic        mem_select_out_n_o,
  input wire logic        timer_select_o,
  input wire logic        sg_select_o,
  input wire logic [7:0]  sg_base_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  a_cs_idle: assert property (!mem_req_i.valid |=> mem_select_out_n_o)
    else $error("cs idle");
  a_cs_range: assert property (mem_req_i.addr[31:16] > 16'h000e |=> mem_select_out_n_o)
    else $error("cs range");
  a_tmr_idle: assert property (!io_valid_i |=> !timer_select_o)
    else $error("timer idle");
  a_sg_idle: assert property (!io_valid_i |=> !sg_select_o)
    else $error("sg idle");
  a_base_rst: assert property ($fell(rst_i) |-> sg_base_o == 8'h04)
    else $error("sg reset");
  a_sg_write: assert property (reg_req_i.wr && reg_req_i.addr == 8'h57
    |=> sg_base_o == $past(reg_req_i.wdata)) else $error("sg write");
  a_sg_hit: assert property (io_valid_i && io_addr_i[15:8] == sg_base_o |=> sg_select_o)
    else $error("sg hit");
  a_read_back: assert property (reg_req_i.wr ##2 reg_req_i.rd
    && reg_req_i.addr == $past(reg_req_i.addr, 2)
    |=> reg_rdata_o == $past(reg_req_i.wdata, 3)) else $error("read back");
endmodule

// ===== verification/mem_master.sv
// partner: memory master presenting one access at a time
module mem_master
  import seg_decode_pkg::*;
(
  input  wire logic   clk_i,
  output mem_req_type req_o
);
  timeunit 1ns;
  timeprecision 100ps;
  initial req_o = '0;
  task automatic access(input logic [31:0] a, input logic w);
    @(posedge clk_i) req_o <= '{1'b1, w, a};
    @(posedge clk_i) req_o <= '{1'b0, ~w, ~a};
    #1;
  endtask
endmodule

// ===== verification/seg_decode_tb.sv
// testbench: register access and decode of the segment decode block
module seg_decode_tb
  import seg_decode_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        io_valid_i = 1'b0;
  logic [15:0] io_addr_i = 16'h0000;
  logic [7:0]  reg_rdata_o, sg_base_o;
  logic        mem_select_out_n_o, timer_select_o, sg_select_o;
  reg_req_type reg_req_i = '0;
  mem_req_type mem_req_i;
  int          miscompares = 0;
  int          n_checks = 0;
  always #12.5 clk_i = ~clk_i;
  seg_decode uut (.*);
  mem_master pm (.clk_i(clk_i), .req_o(mem_req_i));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i) reg_req_i <= '{a, d, 1'b1, 1'b0};
    @(posedge clk_i) reg_req_i <= '{a, d, 1'b0, 1'b0};
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_i) reg_req_i <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk_i) reg_req_i.rd <= 1'b0;
    #1 chk(reg_rdata_o, e);
  endtask
  task automatic mem(input logic [31:0] a, input logic w, input logic e);
    pm.access(a, w);
    chk(mem_select_out_n_o, e);
  endtask
  task automatic io(input logic [15:0] a, input logic t, input logic s);
    @(posedge clk_i) {io_valid_i, io_addr_i} <= {1'b1, a};
    @(posedge clk_i) {io_valid_i, io_addr_i} <= {1'b0, ~a};
    #1 chk(timer_select_o, t);
    chk(sg_select_o, s);
  endtask
  task automatic end_sim;
    if (miscompares == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(8'h54, 8'h00);
    rd(8'h55, 8'h00);
    rd(8'h56, 8'h00);
    rd(8'h57, 8'h04);
    rd(8'h80, 8'h78);
    rd(8'h81, 8'h00);
    rd(8'h60, 8'h00);
    wr(8'h90, 8'h10);
    mem(32'h000c_0000, 1'b0, 1'b1);
    for (int i = 0; i < 24; i++)
    begin
      wr(8'h54 + 8'(i / 8), 8'(1 << (i % 8)));
      mem(32'h000c_3ffc + 32'(i / 2) * 32'h0000_4000, 1'(i), 1'b0);
      mem(32'h000c_0000 + 32'(i / 2) * 32'h0000_4000, ~1'(i), 1'b1);
      wr(8'h54 + 8'(i / 8), 8'h00);
    end
    wr(8'h56, 8'hff);
    wr(8'h90, 8'h00);
    mem(32'h000e_c000, 1'b1, 1'b1);
    wr(8'h90, 8'h10);
    mem(32'h000e_c000, 1'b1, 1'b0);
    mem(32'h001e_c000, 1'b1, 1'b1);
    wr(8'h80, 8'h37);
    wr(8'h81, 8'h12);
    io(16'h1234, 1'b1, 1'b0);
    io(16'h1238, 1'b0, 1'b0);
    wr(8'h80, 8'h36);
    io(16'h1234, 1'b0, 1'b0);
    wr(8'h57, 8'h21);
    rd(8'h57, 8'h21);
    chk(sg_base_o, 8'h21);
    io(16'h2110, 1'b0, 1'b1);
    end_sim;
  end
endmodule
bind seg_decode seg_decode_checker chk (.*);
